// ==== aiu_core.sv ====
// aiu_core.sv: add, subtract, multiply, divide and inclusive-or execution
// assumes one memory port on the same clock answering with a one-cycle ack
`default_nettype none
`include "aiu_regs.svh"

module aiu_core
	import aiu_pkg::*;
#(
	parameter int HALF_CLKS = `AIU_HALF_CYC_CLKS
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// instruction issue
	input wire logic i_start,
	input wire logic [15:0] i_instr,
	input wire logic [14:0] i_pc,
	input wire logic [15:0] i_xreg,
	output logic o_busy,
	output logic o_done,
	output logic o_reject,
	// operand memory
	output logic o_mem_req,
	output logic [14:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_rdata,
	// register access
	input wire logic i_acc_wr,
	input wire logic [15:0] i_acc_wdata,
	input wire logic i_sec_wr,
	input wire logic [15:0] i_sec_wdata,
	input wire logic i_ovf_clr,
	output logic [15:0] o_acc,
	output logic [15:0] o_sec,
	output logic o_ovf
);

	localparam int CW = $clog2(HALF_CLKS + 1);

	aiu_state_t state_reg;
	aiu_op_t op_reg;
	aiu_form_t form_reg;
	logic [15:0] word_reg;
	logic [15:0] x_reg;
	logic [14:0] addr_reg;
	logic [15:0] opnd_reg;
	logic [15:0] acc_reg;
	logic [15:0] sec_reg;
	logic ovf_reg;
	logic [5:0] tgt_reg;
	logic [CW-1:0] clk_cnt_reg;
	logic [5:0] half_reg;
	logic done_reg;
	logic reject_reg;

	logic two_word;
	aiu_op_t dec_op;
	aiu_form_t dec_form;
	logic [14:0] dec_ea;
	logic [5:0] dec_tgt;
	logic start_ok;
	logic [15:0] ext_idx;
	logic [14:0] ext_ea;
	logic [16:0] sum_r;
	logic [16:0] dif_r;
	logic [31:0] prod;
	logic [31:0] dvd;
	logic [31:0] dvs;
	logic [31:0] dvd_mag;
	logic [31:0] dvs_mag;
	logic [31:0] quo;
	logic [31:0] rem;
	logic [2:0] pop;
	logic mul_ovf;
	logic div_ovf;
	logic [5:0] fin_tgt;
	logic fin_go;
	logic [15:0] acc_next;
	logic [15:0] sec_next;
	logic ovf_set;

	// map a 4-bit function pattern onto an operation
	function automatic aiu_op_t fn_decode(input logic [3:0] f);
		case (f)
			`AIU_FN_ADD: fn_decode = AIU_OP_ADD;
			`AIU_FN_SUB: fn_decode = AIU_OP_SUB;
			`AIU_FN_MUL: fn_decode = AIU_OP_MUL;
			`AIU_FN_DIV: fn_decode = AIU_OP_DIV;
			`AIU_FN_OR: fn_decode = AIU_OP_OR;
			`AIU_FN_XOR, `AIU_FN_AND: fn_decode = AIU_OP_FOREIGN;
			default: fn_decode = AIU_OP_NONE;
		endcase
	endfunction

	// magnitude of a 32-bit two's-complement value
	function automatic logic [31:0] mag32(input logic [31:0] v);
		mag32 = v[31] ? 32'(~v + 32'h1) : v;
	endfunction

	// add or subtract with signed overflow in the top bit
	function automatic logic [16:0] add_ovf(input logic [15:0] a, input logic [15:0] b,
			input logic sub);
		logic [15:0] bb;
		logic [15:0] s;
		bb = sub ? ~b : b;
		s = 16'(a + bb + {15'h0, sub});
		add_ovf = {(a[15] == bb[15]) && (s[15] != a[15]), s};
	endfunction

	// instruction decode at issue
	always_comb begin
		two_word = (i_instr[15:12] == `AIU_TWO_PFX) && (i_instr[11:9] == `AIU_TWO_GRP)
			&& (i_instr[8:7] == 2'h0);
		dec_op = two_word ? fn_decode(i_instr[6:3]) : fn_decode(i_instr[15:12]);
		dec_form = AIU_FORM_MEM;
		if (two_word) begin
			dec_form = (i_instr[2:0] == `AIU_X_IMM) ? AIU_FORM_IMM : AIU_FORM_EXT;
		end
		start_ok = i_start && (state_reg == AIU_S_IDLE) && (dec_op != AIU_OP_NONE)
			&& (dec_op != AIU_OP_FOREIGN);
	end

	// one-word effective address: direct, relative, indexed or indirect
	always_comb begin
		case (i_instr[11:9])
			`AIU_M_REL: dec_ea = 15'(i_pc + {6'h0, i_instr[8:0]});
			`AIU_M_XREG: dec_ea = 15'(i_xreg[14:0] + {6'h0, i_instr[8:0]});
			`AIU_M_BREG: dec_ea = 15'(sec_reg[14:0] + {6'h0, i_instr[8:0]});
			`AIU_M_IND: dec_ea = {6'h0, i_instr[8:0]};
			default: dec_ea = {4'h0, i_instr[10:0]};
		endcase
	end

	// least execution length of the decoded instruction
	always_comb begin
		case (dec_op)
			AIU_OP_MUL, AIU_OP_DIV: begin
				case (dec_form)
					AIU_FORM_IMM: dec_tgt = `AIU_HC_MD_IMM;
					AIU_FORM_EXT: dec_tgt = `AIU_HC_MD_EXT;
					default: dec_tgt = `AIU_HC_MD_MEM;
				endcase
			end
			default: dec_tgt = (dec_form == AIU_FORM_EXT) ? `AIU_HC_EXT : `AIU_HC_SHORT;
		endcase
	end

	// second-word operand address with optional indexing
	always_comb begin
		case (word_reg[2:0])
			`AIU_X_XREG: ext_idx = x_reg;
			`AIU_X_BREG: ext_idx = sec_reg;
			default: ext_idx = 16'h0000;
		endcase
		ext_ea = 15'(i_mem_rdata[14:0] + ext_idx[14:0]);
	end

	// arithmetic on accumulator, secondary register and operand
	always_comb begin
		sum_r = add_ovf(acc_reg, opnd_reg, 1'b0);
		dif_r = add_ovf(acc_reg, opnd_reg, 1'b1);
		prod = 32'({{16{sec_reg[15]}}, sec_reg} * {{16{opnd_reg[15]}}, opnd_reg}
			+ {{16{acc_reg[15]}}, acc_reg});
		mul_ovf = (sec_reg == `AIU_MAX_NEG) && (opnd_reg == `AIU_MAX_NEG);
		dvd = {acc_reg[15], acc_reg, sec_reg[14:0]};
		dvs = {{16{opnd_reg[15]}}, opnd_reg};
		dvd_mag = mag32(dvd);
		dvs_mag = mag32(dvs);
		div_ovf = (opnd_reg == 16'h0000) || (dvd_mag > {dvs_mag[16:0], 15'h0000});
		quo = 32'h0000_0000;
		rem = 32'h0000_0000;
		if (opnd_reg != 16'h0000) begin
			quo = $signed(dvd) / $signed(dvs);
			rem = $signed(dvd) % $signed(dvs);
		end
		pop = 3'h0;
		for (int i = 0; i < 4; i++) begin
			pop = 3'(pop + {2'h0, quo[i]});
		end
	end

	// final length: memory divide stretches with the quotient pattern
	always_comb begin
		fin_tgt = tgt_reg;
		if (op_reg == AIU_OP_DIV && form_reg == AIU_FORM_MEM) begin
			fin_tgt = 6'(tgt_reg + {2'h0, pop, 1'b0});
		end
		fin_go = (state_reg == AIU_S_FIN) && (half_reg >= fin_tgt);
	end

	// result selection per operation
	always_comb begin
		acc_next = acc_reg;
		sec_next = sec_reg;
		ovf_set = 1'b0;
		case (op_reg)
			AIU_OP_ADD: begin
				acc_next = sum_r[15:0];
				ovf_set = sum_r[16];
			end
			AIU_OP_SUB: begin
				acc_next = dif_r[15:0];
				ovf_set = dif_r[16];
			end
			AIU_OP_MUL: begin
				if (mul_ovf) begin
					acc_next = `AIU_WORD_RST;
					sec_next = `AIU_WORD_RST;
					ovf_set = 1'b1;
				end else begin
					acc_next = prod[30:15];
					sec_next = {1'b0, prod[14:0]};
				end
			end
			AIU_OP_DIV: begin
				acc_next = rem[15:0];
				sec_next = quo[15:0];
				ovf_set = div_ovf;
			end
			AIU_OP_OR: acc_next = acc_reg | opnd_reg;
			default: acc_next = acc_reg;
		endcase
	end

	// sequencer
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state_reg <= AIU_S_IDLE;
		end else begin
			case (state_reg)
				AIU_S_IDLE: begin
					if (start_ok && dec_form != AIU_FORM_MEM) begin
						state_reg <= AIU_S_WORD2;
					end else if (start_ok && i_instr[11:9] == `AIU_M_IND) begin
						state_reg <= AIU_S_PTR;
					end else if (start_ok) begin
						state_reg <= AIU_S_OPND;
					end
				end
				AIU_S_WORD2: begin
					if (i_mem_ack && form_reg == AIU_FORM_IMM) begin
						state_reg <= AIU_S_FIN;
					end else if (i_mem_ack) begin
						state_reg <= i_mem_rdata[15] ? AIU_S_PTR : AIU_S_OPND;
					end
				end
				AIU_S_PTR: begin
					if (i_mem_ack) begin
						state_reg <= i_mem_rdata[15] ? AIU_S_PTR : AIU_S_OPND;
					end
				end
				AIU_S_OPND: begin
					if (i_mem_ack) begin
						state_reg <= AIU_S_FIN;
					end
				end
				AIU_S_FIN: begin
					if (fin_go) begin
						state_reg <= AIU_S_IDLE;
					end
				end
				default: state_reg <= AIU_S_IDLE;
			endcase
		end
	end

	// instruction capture at issue
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			op_reg <= AIU_OP_NONE;
			form_reg <= AIU_FORM_MEM;
			word_reg <= `AIU_WORD_RST;
			x_reg <= `AIU_WORD_RST;
			tgt_reg <= `AIU_HC_SHORT;
		end else if (start_ok) begin
			op_reg <= dec_op;
			form_reg <= dec_form;
			word_reg <= i_instr;
			x_reg <= i_xreg;
			tgt_reg <= dec_tgt;
		end
	end

	// memory address: operand, second word, pointer chain
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			addr_reg <= 15'h0000;
		end else begin
			case (state_reg)
				AIU_S_IDLE: begin
					if (start_ok) begin
						addr_reg <= (dec_form == AIU_FORM_MEM) ? dec_ea : 15'(i_pc + 15'h0001);
					end
				end
				AIU_S_WORD2: begin
					if (i_mem_ack) begin
						addr_reg <= ext_ea;
					end
				end
				AIU_S_PTR: begin
					if (i_mem_ack) begin
						addr_reg <= i_mem_rdata[14:0];
					end
				end
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// operand capture: word n+1 itself for immediate forms
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			opnd_reg <= `AIU_WORD_RST;
		end else if (i_mem_ack && state_reg == AIU_S_WORD2 && form_reg == AIU_FORM_IMM) begin
			opnd_reg <= i_mem_rdata;
		end else if (i_mem_ack && state_reg == AIU_S_OPND) begin
			opnd_reg <= i_mem_rdata;
		end
	end

	// half-cycle timer, held at zero while idle
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst || state_reg == AIU_S_IDLE) begin
			clk_cnt_reg <= '0;
			half_reg <= 6'h00;
		end else if (clk_cnt_reg == CW'(HALF_CLKS - 1)) begin
			clk_cnt_reg <= '0;
			if (half_reg != `AIU_HC_MAX) begin
				half_reg <= 6'(half_reg + 6'h01);
			end
		end else begin
			clk_cnt_reg <= CW'(clk_cnt_reg + 1'b1);
		end
	end

	// working registers, written at the end of the last cycle or by the load ports while idle
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			acc_reg <= `AIU_WORD_RST;
			sec_reg <= `AIU_WORD_RST;
		end else if (fin_go) begin
			acc_reg <= acc_next;
			sec_reg <= sec_next;
		end else if (state_reg == AIU_S_IDLE) begin
			if (i_acc_wr) begin
				acc_reg <= i_acc_wdata;
			end
			if (i_sec_wr) begin
				sec_reg <= i_sec_wdata;
			end
		end
	end

	// sticky overflow: a set beats a simultaneous clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			ovf_reg <= 1'b0;
		end else if (fin_go && ovf_set) begin
			ovf_reg <= 1'b1;
		end else if (i_ovf_clr) begin
			ovf_reg <= 1'b0;
		end
	end

	// completion and refusal pulses
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			done_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			done_reg <= fin_go;
			reject_reg <= i_start && (state_reg == AIU_S_IDLE) && !start_ok;
		end
	end

	// outputs
	assign o_busy = (state_reg != AIU_S_IDLE);
	assign o_done = done_reg;
	assign o_reject = reject_reg;
	assign o_mem_req = (state_reg == AIU_S_WORD2) || (state_reg == AIU_S_PTR)
		|| (state_reg == AIU_S_OPND);
	assign o_mem_addr = addr_reg;
	assign o_acc = acc_reg;
	assign o_sec = sec_reg;
	assign o_ovf = ovf_reg;

endmodule

`default_nettype wire

// ==== aiu_regs.svh ====
// aiu_regs.svh: constants of the arithmetic/logic instruction unit
// assumes a 200 MHz system clock and 16-bit two's-complement words
`ifndef AIU_REGS_SVH
`define AIU_REGS_SVH

// clock and machine timing
`define AIU_CLK_NS 5
`define AIU_HALF_CYC_NS 500
`define AIU_HALF_CYC_CLKS ((`AIU_HALF_CYC_NS + `AIU_CLK_NS - 1) / `AIU_CLK_NS)

// instruction codes
`define AIU_TWO_PFX 4'h0
`define AIU_TWO_GRP 3'h6
`define AIU_FN_OR 4'h9
`define AIU_FN_ADD 4'ha
`define AIU_FN_XOR 4'hb
`define AIU_FN_SUB 4'hc
`define AIU_FN_AND 4'hd
`define AIU_FN_MUL 4'he
`define AIU_FN_DIV 4'hf

// addressing fields
`define AIU_X_IMM 3'h0
`define AIU_X_XREG 3'h2
`define AIU_X_BREG 3'h3
`define AIU_M_REL 3'h4
`define AIU_M_XREG 3'h5
`define AIU_M_BREG 3'h6
`define AIU_M_IND 3'h7

// data values
`define AIU_MAX_NEG 16'h8000
`define AIU_WORD_RST 16'h0000

// execution length in half cycles
`define AIU_HC_SHORT 6'h04
`define AIU_HC_EXT 6'h06
`define AIU_HC_MD_MEM 6'h14
`define AIU_HC_MD_IMM 6'h11
`define AIU_HC_MD_EXT 6'h13
`define AIU_HC_MAX 6'h3f

`endif

// ==== aiu_pkg.sv ====
// aiu_pkg.sv: types of the arithmetic/logic instruction unit
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package aiu_pkg;
	// sequencer states, one-hot
	typedef enum logic [4:0] {
		AIU_S_IDLE = 5'h01,
		AIU_S_WORD2 = 5'h02,
		AIU_S_PTR = 5'h04,
		AIU_S_OPND = 5'h08,
		AIU_S_FIN = 5'h10
	} aiu_state_t;

	// operation classes
	typedef enum logic [2:0] {
		AIU_OP_NONE,
		AIU_OP_ADD,
		AIU_OP_SUB,
		AIU_OP_MUL,
		AIU_OP_DIV,
		AIU_OP_OR,
		AIU_OP_FOREIGN
	} aiu_op_t;

	// addressing forms
	typedef enum logic [1:0] {
		AIU_FORM_MEM,
		AIU_FORM_IMM,
		AIU_FORM_EXT
	} aiu_form_t;
endpackage

`default_nettype wire

// ==== aiu_core_assertions.sv ====
// aiu_core_assertions.sv: port checker for aiu_core
// assumes bind into aiu_core, one clock, synchronous active-low reset
`default_nettype none
module aiu_core_assertions #(
	parameter int HALF_CLKS = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic [15:0] i_instr,
	input wire logic [14:0] i_pc,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_reject,
	input wire logic o_mem_req,
	input wire logic [14:0] o_mem_addr,
	input wire logic [15:0] o_acc,
	input wire logic [15:0] o_sec,
	input wire logic o_ovf
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cls_reg;
	logic [15:0] busy_cnt_reg;
	// class of a word: 0 refused, 1 add/sub, 2 or, 3 mul/div
	function automatic logic [1:0] cls(input logic [15:0] w);
		logic [3:0] f;
		f = (w[15:7] == 9'h018) ? w[6:3] : w[15:12];
		case (f)
			4'h9: return 2'h2;
			4'ha, 4'hc: return 2'h1;
			4'he, 4'hf: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction
	// class latched at issue
	always_ff @(posedge i_sys_clk) begin
		if (i_start && !o_busy) begin
			cls_reg <= cls(i_instr);
		end
	end
	// cycles spent busy
	always_ff @(posedge i_sys_clk) begin
		busy_cnt_reg <= o_busy ? busy_cnt_reg + 16'h1 : 16'h0;
	end
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	a_take_busy: assert property (i_start && !o_busy && cls(i_instr) != 2'h0 |=> o_busy && !o_reject)
		else $error("valid issue not taken");
	a_refuse_code: assert property (i_start && !o_busy && cls(i_instr) == 2'h0 |=> o_reject && !o_busy)
		else $error("foreign code not refused");
	a_refuse_busy: assert property (i_start && o_busy |=> !o_reject)
		else $error("issue while busy not silently ignored");
	a_imm_addr: assert property (i_start && !o_busy && cls(i_instr) != 2'h0 && i_instr[15:7] == 9'h018
		&& i_instr[2:0] == 3'h0 |=> o_mem_req && o_mem_addr == $past(i_pc) + 15'h1)
		else $error("immediate operand not fetched from n+1");
	a_short_time: assert property (o_done && cls_reg != 2'h3 |-> busy_cnt_reg >= 4 * HALF_CLKS)
		else $error("short operation finished early");
	a_md_time: assert property (o_done && cls_reg == 2'h3 |-> busy_cnt_reg >= 17 * HALF_CLKS)
		else $error("multiply or divide finished early");
	a_done_bound: assert property ($rose(o_busy) |-> ##[1:400] o_done)
		else $error("operation never finished");
	a_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
		else $error("done not a single pulse");
	a_hold_regs: assert property (o_busy && $past(o_busy) |-> $stable(o_acc) && $stable(o_sec)
		&& $stable(o_ovf))
		else $error("registers changed mid-operation");
	a_or_flags: assert property (o_done && cls_reg != 2'h3 |-> $stable(o_sec)
		&& (cls_reg != 2'h2 || $stable(o_ovf)))
		else $error("short operation altered other registers");
	a_mem_busy: assert property (o_mem_req |-> o_busy)
		else $error("memory read while idle");
endmodule

bind aiu_core aiu_core_assertions #(.HALF_CLKS(HALF_CLKS)) u_aiu_core_assertions (
	.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(i_start), .i_instr(i_instr),
	.i_pc(i_pc), .o_busy(o_busy), .o_done(o_done), .o_reject(o_reject),
	.o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_acc(o_acc), .o_sec(o_sec),
	.o_ovf(o_ovf)
);
`default_nettype wire

// ==== aiu_mem_model.sv ====
// aiu_mem_model.sv: operand memory behind aiu_core
// assumes the bench fills mem and picks the answer latency
`default_nettype none
module aiu_mem_model (
	input wire logic i_sys_clk,
	input wire logic i_req,
	input wire logic [14:0] i_addr,
	input wire logic [1:0] i_lat,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:32767];
	logic [1:0] wait_reg;
	initial begin
		o_ack = 1'b0;
		o_rdata = 16'h0;
		wait_reg = 2'h0;
	end
	// one-cycle ack after i_lat waits; data scrambles off the ack cycle
	always @(posedge i_sys_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack) begin
			if (wait_reg == i_lat) begin
				o_ack <= 1'b1;
				o_rdata <= mem[i_addr];
				wait_reg <= 2'h0;
			end else begin
				wait_reg <= wait_reg + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== arith_logic_instruction_unit_tb.sv ====
// arith_logic_instruction_unit_tb.sv: random and corner runs of aiu_core
// assumes aiu_mem_model as operand memory and a half cycle of 2 clocks
`default_nettype none
module arith_logic_instruction_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, start = 1'b0, acc_wr = 1'b0, sec_wr = 1'b0, ovf_clr = 1'b0;
	logic [15:0] instr = 16'h0, xreg = 16'h0, acc_wd = 16'h0, sec_wd = 16'h0;
	logic [14:0] pc = 15'h0;
	logic [1:0] lat = 2'h0;
	logic busy, done, reject, mem_req, mem_ack, ovf, eo = 1'b0;
	logic [14:0] mem_addr;
	logic [15:0] mem_rdata, acc, sec, ma, mb, mm;
	logic [3:0] fn;
	logic [3:0] fns [5] = '{4'h9, 4'ha, 4'hc, 4'he, 4'hf};
	int err_count = 0, num_checks = 0, seed = 492;
	aiu_core #(.HALF_CLKS(2)) u_aiu_core (
		.i_sys_clk(clk), .i_nrst(nrst), .i_start(start), .i_instr(instr), .i_pc(pc),
		.i_xreg(xreg), .o_busy(busy), .o_done(done), .o_reject(reject),
		.o_mem_req(mem_req), .o_mem_addr(mem_addr), .i_mem_ack(mem_ack),
		.i_mem_rdata(mem_rdata), .i_acc_wr(acc_wr), .i_acc_wdata(acc_wd),
		.i_sec_wr(sec_wr), .i_sec_wdata(sec_wd), .i_ovf_clr(ovf_clr),
		.o_acc(acc), .o_sec(sec), .o_ovf(ovf)
	);
	aiu_mem_model u_aiu_mem_model (
		.i_sys_clk(clk), .i_req(mem_req), .i_addr(mem_addr), .i_lat(lat),
		.o_ack(mem_ack), .o_rdata(mem_rdata)
	);
	always #2.5 clk = ~clk;
	// expected {undefined, overflow, acc, sec} after one operation
	function automatic logic [33:0] model(input logic [3:0] f, input logic [15:0] a, b, m,
		input logic o);
		logic signed [31:0] p, d, n;
		logic [15:0] s;
		logic v;
		case (f)
			4'h9: return {1'b0, o, a | m, b};
			4'ha: begin
				s = a + m;
				return {1'b0, o | (a[15] == m[15] && s[15] != a[15]), s, b};
			end
			4'hc: begin
				s = a - m;
				return {1'b0, o | (a[15] != m[15] && s[15] != a[15]), s, b};
			end
			4'he: begin
				if (b == 16'h8000 && m == 16'h8000) return {2'b01, 32'h0};
				p = $signed(b) * $signed(m) + $signed(a);
				return {1'b0, o, p[30:15], 1'b0, p[14:0]};
			end
			default: begin
				d = $signed({a, b[14:0]});
				n = $signed(m);
				v = n == 0 || (d < 0 ? -d : d) > ((n < 0 ? -n : n) <<< 15);
				p = v ? 0 : d / n;
				d = v ? 0 : d % n;
				return {v, o | v, d[15:0], p[15:0]};
			end
		endcase
	endfunction
	// compare and count
	task automatic check(input logic [15:0] seen, expd);
		num_checks++;
		if (seen !== expd) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, expd);
		end
	endtask
	// verdict and end of run
	task automatic complete_run();
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// one issue; a second issue and a load while busy must be ignored
	task automatic run_op(input logic [3:0] f, input int form, input logic [15:0] a, b, m);
		logic [8:0] aw;
		logic [14:0] oa;
		logic [33:0] r;
		aw = 9'($random(seed));
		oa = 15'h2000 + 15'(aw);
		xreg = {8'h10, 8'($random(seed))};
		pc = {3'h4, 12'($random(seed))};
		lat = 2'($random(seed));
		case (form)
			0: oa = {6'h0, aw};
			1: oa = xreg[14:0] + {6'h0, aw};
			2: u_aiu_mem_model.mem[aw] = {1'b0, oa};
			3: oa = pc + 15'h1;
			5: oa = pc + {6'h0, aw};
			default: begin
				u_aiu_mem_model.mem[pc + 15'h1] = 16'h8600;
				u_aiu_mem_model.mem[xreg[14:0] + 15'h0600] = {1'b0, oa};
			end
		endcase
		u_aiu_mem_model.mem[oa] = m;
		if (form == 3 || form == 4) instr = {9'h018, f, form == 3 ? 3'h0 : 3'h2};
		else instr = {f, form == 0 ? 3'h0 : (form == 1 ? 3'h5 : (form == 2 ? 3'h7 : 3'h4)), aw};
		@(negedge clk);
		acc_wd = a;
		sec_wd = b;
		acc_wr = 1'b1;
		sec_wr = 1'b1;
		ovf_clr = 1'($random(seed));
		eo = eo & !ovf_clr;
		@(negedge clk);
		acc_wr = 1'b0;
		sec_wr = 1'b0;
		ovf_clr = 1'b0;
		start = 1'b1;
		@(negedge clk);
		acc_wr = 1'b1;
		acc_wd = ~a;
		@(negedge clk);
		check(16'(reject), 16'h0);
		start = 1'b0;
		acc_wr = 1'b0;
		for (int k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk);
		r = model(f, a, b, m, eo);
		eo = r[32];
		check(16'(done), 16'h1);
		check(16'(ovf), 16'(eo));
		if (!r[33]) begin
			check(acc, r[31:16]);
			check(sec, r[15:0]);
		end
	endtask
	// refused code is flagged, leaves the unit idle and leaves acc alone
	task automatic refuse(input logic [15:0] w);
		logic [15:0] old;
		old = acc;
		@(negedge clk);
		instr = w;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		check(16'(reject), 16'h1);
		check(16'(busy), 16'h0);
		check(acc, old);
	endtask
	// reset, corner cases, then random operations
	initial begin
		repeat (8) @(negedge clk);
		check(acc, 16'h0);
		check(16'(ovf), 16'h0);
		nrst = 1'b1;
		refuse({4'hb, 12'h123});
		refuse({9'h018, 4'hd, 3'h0});
		refuse(16'h4123);
		run_op(4'ha, 3, 16'h7fff, 16'h1234, 16'h0002);
		run_op(4'hc, 0, 16'h8000, 16'h1234, 16'h0003);
		run_op(4'he, 4, 16'h1234, 16'h8000, 16'h8000);
		run_op(4'hf, 2, 16'h0001, 16'h0000, 16'h0000);
		run_op(4'h9, 1, 16'h0f0f, 16'h1234, 16'h3333);
		for (int i = 0; i < 200; i++) begin
			fn = fns[{$random(seed)} % 5];
			ma = $random(seed);
			mb = $random(seed);
			mm = $random(seed);
			if (fn == 4'hf && mm[0]) begin
				ma = {{3{ma[15]}}, ma[15:3]};
				mm[14] = ~mm[15];
			end
			run_op(fn, {$random(seed)} % 6, ma, mb, mm);
		end
		complete_run();
	end
	// watchdog against a hung handshake
	initial begin
		#400000;
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
